// file: rtl/pbss_map.vh
// Constants for the pipelined burst synchronous memory port.
// Assumes one clock; every synchronous pin is launched from that clock.
//
// Functional notes
// - All synchronous inputs are captured only on the rising clock edge.
// - Address and select state load only on an edge with an active strobe.
// - The array holds 32,768 words of 32 bits, one word per address.
// - A captured address loads its two low bits into the burst counter.
// - Advance sampled low during a burst steps the burst counter.
// - A four-word read burst delivers words in a 3-1-1-1 clock pattern.
// - The counter follows an interleaved or a linear sequence, user selected.
// - Address, data and write controls register together; the write self-times.
// - Byte writes need byte-write enable low; lane selects pick the bytes.
// - Global write low writes all four bytes, ignoring lane controls.
// - Selected only when select one low, select two high, select three low.
// - The processor strobe is ignored while select one is high.
// - With both strobes active and select one low, only the processor strobe is acted on.
// - Read data leaves via output registers from the previously addressed word.
// - Output enable drives the bus asynchronously; masked on first read after deselect.
`ifndef PBSS_MAP_VH
`define PBSS_MAP_VH

// ==========================================================
// Array geometry
`define PBSS_ADDR_W 15
`define PBSS_DEPTH 32768
`define PBSS_DATA_W 32
`define PBSS_LANES 4
`define PBSS_LANE_W 8
`define PBSS_BURST_W 2

// ==========================================================
// Reset values and codes
`define PBSS_LANES_ALL 4'hf
`define PBSS_LANES_NONE 4'h0
`define PBSS_DATA_RST 32'h0000_0000
`define PBSS_ADDR_RST 15'h0000
`define PBSS_ST_DESEL 1'b0
`define PBSS_ST_ACTIVE 1'b1

`endif

// file: rtl/pbss_burst_ctr.v
// Two-bit burst address counter with interleaved or linear order.
// Assumes load and step come from logic on the same clock.
`timescale 1ns/1ps
`include "pbss_map.vh"

module pbss_burst_ctr #(
  parameter W = `PBSS_BURST_W
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire load_i,
  input wire [W-1:0] load_val_i,
  input wire step_i,
  input wire interleave_i,
  output wire [W-1:0] low_o
);

  reg [W-1:0] start_reg;
  reg [W-1:0] count_reg;

  // ==========================================================
  // Counter state
  // Start point load
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_reg <= {W{1'b0}};
      count_reg <= {W{1'b0}};
    end else if (load_i) begin
      start_reg <= load_val_i;
      count_reg <= {W{1'b0}};
    end else if (step_i) begin
      count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================
  // Sequence select
  // Interleaved or linear
  // Xor gives the interleaved order; the sum drops its carry so it stays in the group
  assign low_o = interleave_i ? (start_reg ^ count_reg) : (start_reg + count_reg);

endmodule

// file: rtl/pbss_port.v
// Pipelined burst synchronous memory port: 32K x 32 array, two address
// strobes, burst counter, self-timed byte or global writes, output registers.
// Assumes the host drives all synchronous pins from mclk_i, and resolves the
// shared data wire from dq_o and dq_oe_o outside this module.
`timescale 1ns/1ps
`include "pbss_map.vh"

module pbss_port #(
  parameter ADDR_W = `PBSS_ADDR_W,
  parameter DEPTH = `PBSS_DEPTH,
  parameter DATA_W = `PBSS_DATA_W
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire [DATA_W-1:0] dq_i,
  output wire [DATA_W-1:0] dq_o,
  output wire dq_oe_o,
  input wire output_enable_n_i,
  input wire processor_addr_strobe_n_i,
  input wire controller_addr_strobe_n_i,
  input wire burst_advance_n_i,
  input wire [`PBSS_LANES-1:0] byte_lane_select_n_i,
  input wire byte_write_enable_n_i,
  input wire global_write_n_i,
  input wire chip_select_primary_n_i,
  input wire chip_select_depth_hi_i,
  input wire chip_select_depth_n_i,
  input wire burst_order_i
);

  // ==========================================================
  // Declarations
  reg [DATA_W-1:0] mem [0:DEPTH-1];
  reg order_meta_reg;
  reg order_sync_reg;
  reg state_reg;
  reg state_next;
  reg [ADDR_W-1:0] base_reg;
  reg [ADDR_W-1:0] base_next;
  reg [ADDR_W-1:0] wr_addr_reg;
  reg [DATA_W-1:0] wr_data_reg;
  reg [`PBSS_LANES-1:0] wr_lanes_reg;
  reg [`PBSS_LANES-1:0] lanes_now;
  reg rd_cyc_reg;
  reg rd_cyc_next;
  reg rd_pipe_reg;
  reg [DATA_W-1:0] rd_word_reg;
  reg [DATA_W-1:0] dq_out_reg;
  reg oe_mask_reg;
  reg oe_mask_next;
  reg load;
  reg step;
  reg wr_now;
  reg [ADDR_W-1:0] wr_addr_now;
  wire [`PBSS_BURST_W-1:0] burst_low;
  wire [ADDR_W-1:0] cur_addr;
  wire selected;
  wire proc_start;
  wire ctrl_start;
  wire wr_req;
  integer i;

  // ==========================================================
  // Strap synchroniser
  // The strap is static, but it still comes off a pin, so it is synchronised
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      order_meta_reg <= 1'b1;
      order_sync_reg <= 1'b1;
    end else begin
      order_meta_reg <= burst_order_i;
      order_sync_reg <= order_meta_reg;
    end
  end

  // ==========================================================
  // Strobe and select decode
  // Three-way select
  assign selected = ~chip_select_primary_n_i & chip_select_depth_hi_i & ~chip_select_depth_n_i;
  assign proc_start = ~processor_addr_strobe_n_i & ~chip_select_primary_n_i;
  assign ctrl_start = ~controller_addr_strobe_n_i & ~proc_start;

  // Lane mask for this edge
  always @* begin
    lanes_now = `PBSS_LANES_NONE;
    if (!global_write_n_i) begin
      lanes_now = `PBSS_LANES_ALL;
    end else if (!byte_write_enable_n_i) begin
      lanes_now = ~byte_lane_select_n_i;
    end
  end
  assign wr_req = |lanes_now;

  // Current burst address: captured upper bits plus the counter
  // Upper bits held
  assign cur_addr = {base_reg[ADDR_W-1:`PBSS_BURST_W], burst_low};

  // ==========================================================
  // Cycle control
  // A processor-strobe cycle is always a read; write pins are looked at
  // only from the next edge on, as the host places data a cycle later.
  always @* begin
    state_next = state_reg;
    base_next = base_reg;
    load = 1'b0;
    step = 1'b0;
    wr_now = 1'b0;
    wr_addr_now = cur_addr;
    rd_cyc_next = 1'b0;
    oe_mask_next = 1'b0;
    if (proc_start || ctrl_start) begin
      if (selected) begin
        state_next = `PBSS_ST_ACTIVE;
        base_next = addr_i;
        load = 1'b1;
        wr_now = ctrl_start & wr_req;
        wr_addr_now = addr_i;
        rd_cyc_next = ~(ctrl_start & wr_req);
        oe_mask_next = (state_reg == `PBSS_ST_DESEL) & rd_cyc_next;
      end else begin
        state_next = `PBSS_ST_DESEL;
      end
    end else if (state_reg == `PBSS_ST_ACTIVE) begin
      step = ~burst_advance_n_i;
      wr_now = wr_req;
      rd_cyc_next = ~wr_req;
    end
  end

  // ==========================================================
  // Burst counter
  // Low bits to counter
  pbss_burst_ctr #(
    .W(`PBSS_BURST_W)
  ) u_burst_ctr (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .load_i(load),
    .load_val_i(addr_i[`PBSS_BURST_W-1:0]),
    .step_i(step),
    .interleave_i(order_sync_reg),
    .low_o(burst_low)
  );

  // ==========================================================
  // Control registers
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= `PBSS_ST_DESEL;
      base_reg <= `PBSS_ADDR_RST;
      rd_cyc_reg <= 1'b0;
      rd_pipe_reg <= 1'b0;
      oe_mask_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      base_reg <= base_next;
      rd_cyc_reg <= rd_cyc_next;
      rd_pipe_reg <= rd_cyc_reg;
      oe_mask_reg <= oe_mask_next;
    end
  end

  // ==========================================================
  // Write capture
  // Registered together
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_addr_reg <= `PBSS_ADDR_RST;
      wr_data_reg <= `PBSS_DATA_RST;
      wr_lanes_reg <= `PBSS_LANES_NONE;
    end else begin
      wr_addr_reg <= wr_addr_now;
      wr_data_reg <= dq_i;
      wr_lanes_reg <= wr_now ? lanes_now : `PBSS_LANES_NONE;
    end
  end

  // ==========================================================
  // Array
  // 32K word array
  // Self-timed update
  // The update lands one edge after capture; a read of that word in the
  // same edge sees the old value, which the host must allow for.
  always @(posedge mclk_i) begin
    for (i = 0; i < `PBSS_LANES; i = i + 1) begin
      if (wr_lanes_reg[i]) begin
        mem[wr_addr_reg][i*`PBSS_LANE_W +: `PBSS_LANE_W] <= wr_data_reg[i*`PBSS_LANE_W +: `PBSS_LANE_W];
      end
    end
    rd_word_reg <= mem[cur_addr];
  end

  // ==========================================================
  // Output register
  // Two stages give 3-1-1-1
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dq_out_reg <= `PBSS_DATA_RST;
    end else if (rd_pipe_reg) begin
      dq_out_reg <= rd_word_reg;
    end
  end

  assign dq_o = dq_out_reg;
  // Asynchronous output enable
  // Left unsynchronised on purpose: the bus turn-around must follow the pin at once
  assign dq_oe_o = ~output_enable_n_i & ~oe_mask_reg;

endmodule

// file: dv/pbss_port_sva.sv
// Checker for the burst memory port: output enable masking and read data hold.
// Assumes it is bound to pbss_port and sees only that module's ports.
`timescale 1ns/1ps
module pbss_port_sva #(
  parameter DATA_W = 32
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [DATA_W-1:0] dq_o,
  input wire dq_oe_o,
  input wire output_enable_n_i,
  input wire processor_addr_strobe_n_i,
  input wire controller_addr_strobe_n_i,
  input wire [3:0] byte_lane_select_n_i,
  input wire byte_write_enable_n_i,
  input wire global_write_n_i,
  input wire chip_select_primary_n_i,
  input wire chip_select_depth_hi_i,
  input wire chip_select_depth_n_i
);
  wire sel = !chip_select_primary_n_i && chip_select_depth_hi_i && !chip_select_depth_n_i;
  wire proc = !processor_addr_strobe_n_i && !chip_select_primary_n_i;
  wire start = proc || !controller_addr_strobe_n_i;
  wire lanes = !global_write_n_i || (!byte_write_enable_n_i && byte_lane_select_n_i != 4'hf);
  reg desel_reg;
  // ==========
  // Deselected state tracker; only a start may change it
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) desel_reg <= 1'b1;
    else if (start) desel_reg <= !sel;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_desel; start && !sel; endsequence
  sequence s_idle; desel_reg && !start; endsequence
  sequence s_wr; start && sel && !proc && lanes; endsequence
  a_oe_off: assert property (output_enable_n_i |-> !dq_oe_o)
    else $error("data driven with enable high");
  a_mask_proc: assert property (proc && sel && desel_reg |=> !dq_oe_o ##1 (dq_oe_o == !output_enable_n_i))
    else $error("processor read mask wrong");
  a_mask_ctrl: assert property (start && !proc && sel && !lanes && desel_reg |=> !dq_oe_o)
    else $error("controller read not masked");
  a_oe_active: assert property (start && sel && !desel_reg |=> dq_oe_o == !output_enable_n_i)
    else $error("masked outside deselect exit");
  a_wr_nomask: assert property (s_wr and desel_reg |=> dq_oe_o == !output_enable_n_i)
    else $error("write treated as read");
  // A read taken just before the deselect may still land, so three deselect edges are needed
  a_desel_hold: assert property (s_desel [*3] |=> $stable(dq_o))
    else $error("read data moved while deselected");
  a_idle_hold: assert property (s_idle [*2] |=> $stable(dq_o))
    else $error("blocked strobe started a read");
  // Looks past the read that may sit in the pipe from the edge before the write
  a_wr_quiet: assert property (s_wr |-> ##3 $stable(dq_o))
    else $error("write loaded read data");
endmodule
bind pbss_port pbss_port_sva #(.DATA_W(DATA_W)) pbss_port_sva_inst (.mclk_i, .rst_n_i, .dq_o, .dq_oe_o,
  .output_enable_n_i, .processor_addr_strobe_n_i, .controller_addr_strobe_n_i, .byte_lane_select_n_i,
  .byte_write_enable_n_i, .global_write_n_i, .chip_select_primary_n_i, .chip_select_depth_hi_i,
  .chip_select_depth_n_i);

// file: dv/pbss_dq_bus.sv
// Shared data wire between the port and the host.
// Assumes one clock; an undriven wire flips every cycle, never holds.
`timescale 1ns/1ps
module pbss_dq_bus (
  input wire mclk_i,
  input wire [31:0] dev_d,
  input wire dev_oe,
  input wire [31:0] host_d,
  input wire host_oe,
  output logic [31:0] wire_d
);
  logic [31:0] last_reg = 32'h0000_0000;
  // Device wins only while enabled; stale data must not look valid
  always @* wire_d = dev_oe ? dev_d : (host_oe ? host_d : ~last_reg);
  always @(posedge mclk_i) last_reg <= wire_d;
endmodule

// file: dv/pbss_port_tb_top.sv
// Testbench: host tasks drive the port, the bus model resolves the data wire.
// Assumes 125 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
module pbss_port_tb_top;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, burst_order_i = 1'b1, host_oe = 1'b0;
  logic output_enable_n_i = 1'b1, processor_addr_strobe_n_i = 1'b1, controller_addr_strobe_n_i = 1'b1;
  logic burst_advance_n_i = 1'b1, byte_write_enable_n_i = 1'b1, global_write_n_i = 1'b1;
  logic chip_select_primary_n_i = 1'b1, chip_select_depth_hi_i = 1'b1, chip_select_depth_n_i = 1'b0;
  logic [3:0] byte_lane_select_n_i = 4'hf;
  logic [14:0] addr_i = 15'h5a38;
  logic [31:0] host_d = 32'h0000_0000, shadow [0:7];
  wire [31:0] dq_o, dq_i;
  wire dq_oe_o;
  int failures = 0, total_checks = 0;
  pbss_port pbss_port_inst (.mclk_i, .rst_n_i, .addr_i, .dq_i, .dq_o, .dq_oe_o, .output_enable_n_i,
    .processor_addr_strobe_n_i, .controller_addr_strobe_n_i, .burst_advance_n_i, .byte_lane_select_n_i,
    .byte_write_enable_n_i, .global_write_n_i, .chip_select_primary_n_i, .chip_select_depth_hi_i,
    .chip_select_depth_n_i, .burst_order_i);
  pbss_dq_bus pbss_dq_bus_inst (.mclk_i, .dev_d(dq_o), .dev_oe(dq_oe_o), .host_d, .host_oe, .wire_d(dq_i));
  initial forever #4 mclk_i = ~mclk_i;
  // ==========
  // Compare and report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Strap is only changed under reset, so it stays static in operation
  task do_reset(input logic order);
    rst_n_i = 1'b0;
    burst_order_i = order;
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge mclk_i);
  endtask
  // Controller write; ctl is {select two, global, byte enable, lanes}
  task wr(input logic [2:0] i, input logic [31:0] d, input logic [6:0] ctl);
    logic [31:0] m;
    m = {{8{~ctl[3]}}, {8{~ctl[2]}}, {8{~ctl[1]}}, {8{~ctl[0]}}};
    if (!ctl[5]) m = 32'hffff_ffff;
    else if (ctl[4]) m = 32'h0000_0000;
    if (ctl[6]) shadow[i] = (shadow[i] & ~m) | (d & m);
    {chip_select_depth_hi_i, global_write_n_i, byte_write_enable_n_i, byte_lane_select_n_i} = ctl;
    {controller_addr_strobe_n_i, chip_select_primary_n_i, host_oe} = 3'h1;
    addr_i = 15'h5a38 | i;
    host_d = d;
    @(negedge mclk_i);
    {chip_select_depth_hi_i, global_write_n_i, byte_write_enable_n_i, byte_lane_select_n_i} = 7'h7f;
    {controller_addr_strobe_n_i, host_oe} = 2'h2;
    // One quiet edge so the next call never re-drives these pins in the same time step
    @(negedge mclk_i);
  endtask
  // Deselect, processor strobe blocked by select one high, then a burst of n words
  // Mode is {controller, processor} strobes
  task rd(input logic [2:0] i, input int n, input logic [1:0] mode);
    logic [2:0] w;
    {chip_select_primary_n_i, chip_select_depth_hi_i, controller_addr_strobe_n_i} = 3'h4;
    repeat (3) @(negedge mclk_i);
    {chip_select_depth_hi_i, controller_addr_strobe_n_i, processor_addr_strobe_n_i} = 3'h6;
    repeat (2) @(negedge mclk_i);
    {chip_select_primary_n_i, output_enable_n_i} = 2'h0;
    addr_i = 15'h5a38 | i;
    {controller_addr_strobe_n_i, processor_addr_strobe_n_i} = mode;
    global_write_n_i = |mode;
    @(negedge mclk_i);
    chk(32'(dq_oe_o), 32'h0);
    {controller_addr_strobe_n_i, processor_addr_strobe_n_i, global_write_n_i, burst_advance_n_i} = 4'he;
    @(negedge mclk_i);
    chk(32'(dq_oe_o), 32'h1);
    for (int k = 0; k < n; k++) begin
      @(negedge mclk_i);
      w = burst_order_i ? {i[2], i[1:0] ^ k[1:0]} : {i[2], i[1:0] + k[1:0]};
      chk(dq_i, shadow[w]);
    end
    {burst_advance_n_i, output_enable_n_i} = 2'h3;
  endtask
  // ==========
  // Scenarios
  task t_writes;
    for (int j = 0; j < 8; j++) wr(j[2:0], 32'h1111_1111 * (j + 1), 7'h5f);
    wr(3'h1, 32'hffff_ffff, 7'h65);
    wr(3'h2, 32'hffff_ffff, 7'h70);
    wr(3'h3, 32'h0000_0000, 7'h1f);
    wr(3'h4, 32'h0f0f_0f0f, 7'h50);
    rd(3'h0, 4, 2'h2);
    rd(3'h4, 4, 2'h2);
    $display("writes done");
  endtask
  task t_interleaved;
    rd(3'h6, 4, 2'h1);
    rd(3'h1, 4, 2'h0);
    $display("interleaved done");
  endtask
  task t_linear;
    do_reset(1'b0);
    rd(3'h3, 4, 2'h0);
    rd(3'h6, 4, 2'h2);
    $display("linear done");
  endtask
  initial begin
    do_reset(1'b1);
    t_writes;
    t_interleaved;
    t_linear;
    test_done;
  end
  initial begin
    repeat (3000) @(posedge mclk_i);
    failures++;
    test_done;
  end
endmodule
